//--- shared/gpio_pkg.sv
// shared constants and types for the port 6/7/8 gpio block
package gpio_pkg;
  localparam int PORT_W = 8;
  localparam int PORT7_W = 4;
  localparam int IDX_W = 16;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 17;
  localparam int HDATA_W = 32;
  localparam int SYNC_W = 22;
  localparam logic [IDX_W-1:0] PORT6_DIRECTION_IDX = 16'hFE89;
  localparam logic [IDX_W-1:0] PORT6_DATA_IDX = 16'hFE8B;
  localparam logic [IDX_W-1:0] PORT8_DIRECTION_IDX = 16'hFE8D;
  localparam logic [IDX_W-1:0] PORT7_INPUT_LEVEL_IDX = 16'hFE8E;
  localparam logic [IDX_W-1:0] PORT8_DATA_IDX = 16'hFE8F;
  localparam logic [PORT_W-1:0] DIRECTION_RESET = 8'h00;
  localparam logic [PORT_W-1:0] DATA_RESET = 8'h00;
  localparam logic [PORT_W-1:0] WRITE_ONLY_READ = 8'hFF;
  localparam logic [PORT_W-1:0] UNMAPPED_READ = 8'h00;
  localparam logic [3:0] PORT7_UPPER_READ = 4'h0;
  localparam logic [23:0] HRDATA_UPPER = 24'h000000;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam int TX2_BIT = 7;
  localparam int RX2_BIT = 6;
  localparam int TX1_BIT = 5;
  localparam int RX1_BIT = 4;
  localparam int CLK2_BIT = 3;
  localparam int CLK1_BIT = 2;
  localparam int INT_COUNT = 4;
  typedef struct packed {
    logic sync_mode;
    logic serial_clock_src_hi;
    logic serial_clock_src_lo;
    logic transmit_allow;
    logic rx_allow;
  } serial_ctrl_word_type;
  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe;
  } pin_drive_type;
  typedef struct packed {
    logic rx2;
    logic rx1;
    logic clk2_in;
    logic clk1_in;
    logic [INT_COUNT-1:0] ext_int;
  } pin_route_type;
  typedef enum logic [2:0] {
    CLK_ROLE_ALT = 3'b001,
    CLK_ROLE_OUT = 3'b010,
    CLK_ROLE_IN = 3'b100
  } clock_role_type;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WAIT = 3'b010,
    BUS_DONE = 3'b100
  } bus_state_type;
endpackage : gpio_pkg

//--- hw/sync_two_flop.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ns
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule : sync_two_flop

//--- hw/port8_pin_mux.sv
// pin function selection for port 8
`timescale 1ns/1ns
module port8_pin_mux
  import gpio_pkg::*;
(
  input wire logic [gpio_pkg::PORT_W-1:0] direction,
  input wire logic [gpio_pkg::PORT_W-1:0] data,
  input wire gpio_pkg::serial_ctrl_word_type serial1_ctrl,
  input wire gpio_pkg::serial_ctrl_word_type serial2_ctrl,
  input wire logic serial1_tx,
  input wire logic serial2_tx,
  input wire logic serial1_clock_out,
  input wire logic serial2_clock_out,
  input wire logic [gpio_pkg::INT_COUNT-1:0] ext_int_pin_on,
  output gpio_pkg::pin_drive_type drive,
  output gpio_pkg::pin_route_type route
);
  clock_role_type role1;
  clock_role_type role2;

  // role of a serial clock pin from mode and clock source bits
  function automatic clock_role_type clock_role(input serial_ctrl_word_type c);
    if (!c.sync_mode && !c.serial_clock_src_hi && !c.serial_clock_src_lo) begin
      clock_role = CLK_ROLE_ALT;
    end else if (c.serial_clock_src_hi) begin
      clock_role = CLK_ROLE_IN;
    end else begin
      clock_role = CLK_ROLE_OUT;
    end
  endfunction : clock_role

  always_comb begin
    role1 = clock_role(serial1_ctrl);
    role2 = clock_role(serial2_ctrl);
    drive.out = data;
    drive.oe = direction;
    route = '0;
    if (serial2_ctrl.transmit_allow) begin
      drive.out[TX2_BIT] = serial2_tx;
      drive.oe[TX2_BIT] = 1'b1;
    end
    if (serial2_ctrl.rx_allow) begin
      drive.oe[RX2_BIT] = 1'b0;
      route.rx2 = 1'b1;
    end
    if (serial1_ctrl.transmit_allow) begin
      drive.out[TX1_BIT] = serial1_tx;
      drive.oe[TX1_BIT] = 1'b1;
    end
    if (serial1_ctrl.rx_allow) begin
      drive.oe[RX1_BIT] = 1'b0;
      route.rx1 = 1'b1;
    end
    case (role2)
      CLK_ROLE_OUT: begin
        drive.out[CLK2_BIT] = serial2_clock_out;
        drive.oe[CLK2_BIT] = 1'b1;
      end
      CLK_ROLE_IN: begin
        drive.oe[CLK2_BIT] = 1'b0;
        route.clk2_in = 1'b1;
      end
      default: begin
        if (ext_int_pin_on[3]) begin
          drive.oe[CLK2_BIT] = 1'b0;
          route.ext_int[3] = 1'b1;
        end
      end
    endcase
    case (role1)
      CLK_ROLE_OUT: begin
        drive.out[CLK1_BIT] = serial1_clock_out;
        drive.oe[CLK1_BIT] = 1'b1;
      end
      CLK_ROLE_IN: begin
        drive.oe[CLK1_BIT] = 1'b0;
        route.clk1_in = 1'b1;
      end
      default: begin
        if (ext_int_pin_on[2]) begin
          drive.oe[CLK1_BIT] = 1'b0;
          route.ext_int[2] = 1'b1;
        end
      end
    endcase
    if (ext_int_pin_on[1]) begin
      drive.oe[1] = 1'b0;
      route.ext_int[1] = 1'b1;
    end
    if (ext_int_pin_on[0]) begin
      drive.oe[0] = 1'b0;
      route.ext_int[0] = 1'b1;
    end
  end
endmodule : port8_pin_mux

//--- hw/gpio_ports_six_seven_eight.sv
// top of the port 6/7/8 gpio block with its ahb-lite register slave
// Notes on behaviour
// - direction bit 1 drives data, 0 is input
// - direction registers read back all ones
// - direction clears on reset and hardware standby
// - software standby keeps direction and output drive
// - data registers clear on reset, hardware standby
// - data read: latch for outputs, pin for inputs
// - port 7 is four input-only pins
// - software standby returns port 8 to gpio
// - port 8 bit 7 is serial2 transmit
// - port 8 bit 6 is serial2 receive
// - port 8 bit 5 is serial1 transmit
// - port 8 bit 4 is serial1 receive
// - port 8 bit 3 is serial2 clock pin
// - bit 3 else external interrupt 3 or gpio
// - port 8 bit 2 is serial1 clock pin
// - bit 2 else external interrupt 2 or gpio
// - bit 1 external interrupt 1 when enabled
// - bit 0 external interrupt 0 when enabled
`timescale 1ns/1ns
module gpio_ports_six_seven_eight
  import gpio_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [gpio_pkg::HDATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [gpio_pkg::HDATA_W-1:0] hrdata,
  output logic [1:0] hresp,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic [gpio_pkg::PORT_W-1:0] port6_in,
  input wire logic [gpio_pkg::PORT7_W-1:0] port7_in,
  input wire logic [gpio_pkg::PORT_W-1:0] port8_in,
  input wire gpio_pkg::serial_ctrl_word_type serial_unit_one,
  input wire gpio_pkg::serial_ctrl_word_type serial_unit_two,
  input wire logic serial1_tx_pin,
  input wire logic serial2_tx_pin,
  input wire logic serial1_clock_out,
  input wire logic serial2_clock_out,
  input wire logic [gpio_pkg::INT_COUNT-1:0] ext_int_pin_on,
  output gpio_pkg::pin_drive_type port6_drive,
  output gpio_pkg::pin_drive_type port8_drive,
  output logic serial1_rx_pin,
  output logic serial2_rx_pin,
  output logic serial1_clock_pin,
  output logic serial2_clock_pin,
  output logic [gpio_pkg::INT_COUNT-1:0] ext_int_n
);
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_level;
  logic [PORT_W-1:0] port6_level;
  logic [PORT7_W-1:0] port7_level;
  logic [PORT_W-1:0] port8_level;
  logic hw_standby_level;
  logic sw_standby_level;

  logic [PORT_W-1:0] port6_direction;
  logic [PORT_W-1:0] port6_data;
  logic [PORT_W-1:0] port8_direction;
  logic [PORT_W-1:0] port8_data;
  logic [PORT_W-1:0] next_port6_direction;
  logic [PORT_W-1:0] next_port6_data;
  logic [PORT_W-1:0] next_port8_direction;
  logic [PORT_W-1:0] next_port8_data;

  bus_state_type bus_state;
  bus_state_type next_bus_state;
  logic [IDX_W-1:0] addr_idx;
  logic [IDX_W-1:0] next_addr_idx;
  logic write_flag;
  logic next_write_flag;
  logic next_hreadyout;
  logic [HDATA_W-1:0] next_hrdata;
  logic [PORT_W-1:0] read_byte;
  logic addr_accept;
  logic write_commit;

  serial_ctrl_word_type serial1_live;
  serial_ctrl_word_type serial2_live;
  logic [INT_COUNT-1:0] ext_int_live;
  pin_drive_type port8_mux_drive;
  pin_route_type port8_route;
  pin_drive_type next_port6_drive;
  pin_drive_type next_port8_drive;
  logic next_serial1_rx_pin;
  logic next_serial2_rx_pin;
  logic next_serial1_clock_pin;
  logic next_serial2_clock_pin;
  logic [INT_COUNT-1:0] next_ext_int_n;

  // latch for output pins, pin level for input pins
  function automatic logic [PORT_W-1:0] merge_read(
    input logic [PORT_W-1:0] dir,
    input logic [PORT_W-1:0] latch,
    input logic [PORT_W-1:0] level
  );
    merge_read = (dir & latch) | (~dir & level);
  endfunction : merge_read

  assign sync_raw = {hw_standby, sw_standby, port8_in, port7_in, port6_in};

  sync_two_flop #(
    .WIDTH(SYNC_W)
  ) pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(sync_raw),
    .sync_out(sync_level)
  );

  assign port6_level = sync_level[PORT_W-1:0];
  assign port7_level = sync_level[PORT_W+PORT7_W-1:PORT_W];
  assign port8_level = sync_level[2*PORT_W+PORT7_W-1:PORT_W+PORT7_W];
  assign sw_standby_level = sync_level[SYNC_W-2];
  assign hw_standby_level = sync_level[SYNC_W-1];

  // serial and interrupt pin functions are masked off during software standby
  assign serial1_live = sw_standby_level ? '0 : serial_unit_one;
  assign serial2_live = sw_standby_level ? '0 : serial_unit_two;
  assign ext_int_live = sw_standby_level ? '0 : ext_int_pin_on;

  port8_pin_mux port8_select (
    .direction(port8_direction),
    .data(port8_data),
    .serial1_ctrl(serial1_live),
    .serial2_ctrl(serial2_live),
    .serial1_tx(serial1_tx_pin),
    .serial2_tx(serial2_tx_pin),
    .serial1_clock_out(serial1_clock_out),
    .serial2_clock_out(serial2_clock_out),
    .ext_int_pin_on(ext_int_live),
    .drive(port8_mux_drive),
    .route(port8_route)
  );

  // bus handshake: one wait cycle, then the answer
  assign addr_accept = hsel && htrans[1] && hready;
  assign write_commit = (bus_state == BUS_WAIT) && write_flag;

  always_comb begin
    next_bus_state = bus_state;
    next_addr_idx = addr_idx;
    next_write_flag = write_flag;
    next_hreadyout = hreadyout;
    case (bus_state)
      BUS_IDLE, BUS_DONE: begin
        if (addr_accept) begin
          next_bus_state = BUS_WAIT;
          next_addr_idx = haddr[IDX_MSB:IDX_LSB];
          next_write_flag = hwrite;
          next_hreadyout = 1'b0;
        end else begin
          next_bus_state = BUS_IDLE;
          next_hreadyout = 1'b1;
        end
      end
      BUS_WAIT: begin
        next_bus_state = BUS_DONE;
        next_hreadyout = 1'b1;
      end
      default: begin
        next_bus_state = BUS_IDLE;
        next_hreadyout = 1'b1;
      end
    endcase
  end

  // read mux, sampled in the wait cycle
  always_comb begin
    case (addr_idx)
      PORT6_DIRECTION_IDX: read_byte = WRITE_ONLY_READ;
      PORT8_DIRECTION_IDX: read_byte = WRITE_ONLY_READ;
      PORT6_DATA_IDX: read_byte = merge_read(port6_direction, port6_data, port6_level);
      PORT8_DATA_IDX: read_byte = merge_read(port8_direction, port8_data, port8_level);
      PORT7_INPUT_LEVEL_IDX: read_byte = {PORT7_UPPER_READ, port7_level};
      default: read_byte = UNMAPPED_READ;
    endcase
    if ((bus_state == BUS_WAIT) && !write_flag) begin
      next_hrdata = {HRDATA_UPPER, read_byte};
    end else begin
      next_hrdata = hrdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= BUS_IDLE;
      addr_idx <= '0;
      write_flag <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= '0;
      hresp <= HRESP_OKAY;
    end else begin
      bus_state <= next_bus_state;
      addr_idx <= next_addr_idx;
      write_flag <= next_write_flag;
      hreadyout <= next_hreadyout;
      hrdata <= next_hrdata;
      hresp <= HRESP_OKAY;
    end
  end

  // port registers; port 7 has none, so writes there fall away
  always_comb begin
    next_port6_direction = port6_direction;
    next_port6_data = port6_data;
    next_port8_direction = port8_direction;
    next_port8_data = port8_data;
    if (hw_standby_level) begin
      next_port6_direction = DIRECTION_RESET;
      next_port8_direction = DIRECTION_RESET;
      next_port6_data = DATA_RESET;
      next_port8_data = DATA_RESET;
    end else if (write_commit) begin
      case (addr_idx)
        PORT6_DIRECTION_IDX: next_port6_direction = hwdata[PORT_W-1:0];
        PORT6_DATA_IDX: next_port6_data = hwdata[PORT_W-1:0];
        PORT8_DIRECTION_IDX: next_port8_direction = hwdata[PORT_W-1:0];
        PORT8_DATA_IDX: next_port8_data = hwdata[PORT_W-1:0];
        default: next_port6_data = port6_data;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port6_direction <= DIRECTION_RESET;
      port8_direction <= DIRECTION_RESET;
      port6_data <= DATA_RESET;
      port8_data <= DATA_RESET;
    end else begin
      port6_direction <= next_port6_direction;
      port8_direction <= next_port8_direction;
      port6_data <= next_port6_data;
      port8_data <= next_port8_data;
    end
  end

  // pin drive and peripheral inputs; unrouted inputs idle high
  always_comb begin
    next_port6_drive.out = port6_data;
    next_port6_drive.oe = port6_direction;
    next_port8_drive = port8_mux_drive;
    next_serial1_rx_pin = port8_route.rx1 ? port8_level[RX1_BIT] : 1'b1;
    next_serial2_rx_pin = port8_route.rx2 ? port8_level[RX2_BIT] : 1'b1;
    next_serial1_clock_pin = port8_route.clk1_in ? port8_level[CLK1_BIT] : 1'b1;
    next_serial2_clock_pin = port8_route.clk2_in ? port8_level[CLK2_BIT] : 1'b1;
    for (int i = 0; i < INT_COUNT; i++) begin
      next_ext_int_n[i] = port8_route.ext_int[i] ? port8_level[i] : 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port6_drive <= '0;
      port8_drive <= '0;
      serial1_rx_pin <= 1'b1;
      serial2_rx_pin <= 1'b1;
      serial1_clock_pin <= 1'b1;
      serial2_clock_pin <= 1'b1;
      ext_int_n <= '1;
    end else begin
      port6_drive <= next_port6_drive;
      port8_drive <= next_port8_drive;
      serial1_rx_pin <= next_serial1_rx_pin;
      serial2_rx_pin <= next_serial2_rx_pin;
      serial1_clock_pin <= next_serial1_clock_pin;
      serial2_clock_pin <= next_serial2_clock_pin;
      ext_int_n <= next_ext_int_n;
    end
  end
endmodule : gpio_ports_six_seven_eight

//--- sim/board_pins.sv
// board-side model: resolves each port 6 and port 8 pin from the block's drive and the board level
`timescale 1ns/1ns
module board_pins
  import gpio_pkg::*;
(
  input wire gpio_pkg::pin_drive_type port6_drive,
  input wire gpio_pkg::pin_drive_type port8_drive,
  input wire logic [7:0] board6,
  input wire logic [7:0] board8,
  output logic [7:0] port6_in,
  output logic [7:0] port8_in
);
  assign port6_in = (port6_drive.out & port6_drive.oe) | (board6 & ~port6_drive.oe);
  assign port8_in = (port8_drive.out & port8_drive.oe) | (board8 & ~port8_drive.oe);
endmodule : board_pins

//--- sim/gpio_ports_sva.sv
// assertion checker for the port 6/7/8 gpio block
`timescale 1ns/1ns
module gpio_ports_sva
  import gpio_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [gpio_pkg::HDATA_W-1:0] hrdata,
  input wire logic [1:0] hresp,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic [gpio_pkg::PORT_W-1:0] port8_in,
  input wire gpio_pkg::serial_ctrl_word_type serial_unit_two,
  input wire logic serial2_tx_pin,
  input wire logic serial2_clock_out,
  input wire logic [gpio_pkg::INT_COUNT-1:0] ext_int_pin_on,
  input wire gpio_pkg::pin_drive_type port6_drive,
  input wire gpio_pkg::pin_drive_type port8_drive,
  input wire logic serial2_rx_pin,
  input wire logic [gpio_pkg::INT_COUNT-1:0] ext_int_n
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence rd_taken_s(logic [31:0] a);
    hsel && htrans[1] && hready && !hwrite && haddr == a;
  endsequence
  sequence rd_done_s;
    !hreadyout ##1 hreadyout;
  endsequence
  okay_resp_a: assert property (hresp == 2'h0) else $error("response not okay");
  dir_read_ones_a: assert property (rd_taken_s(32'h0003FA24) |=> rd_done_s ##0 hrdata == 32'h000000FF)
    else $error("direction read not all ones");
  p7_upper_a: assert property (rd_taken_s(32'h0003FA38) |=> rd_done_s ##0 hrdata[31:4] == 28'h0000000)
    else $error("port 7 upper bits not fixed");
  hw_clear_a: assert property (hw_standby [*6] |-> port6_drive == 16'h0000) else $error("standby did not clear");
  sw_gpio_a: assert property (sw_standby [*5] |-> serial2_rx_pin && ext_int_n == 4'hF)
    else $error("peripheral kept pin in standby");
  tx2_route_a: assert property ((serial_unit_two.transmit_allow && !sw_standby && $stable(serial2_tx_pin)) [*5]
    |-> port8_drive.oe[7] && port8_drive.out[7] == serial2_tx_pin) else $error("tx2 not routed");
  rx2_route_a: assert property ((serial_unit_two.rx_allow && !sw_standby && $stable(port8_in[6])) [*5]
    |-> !port8_drive.oe[6] && serial2_rx_pin == port8_in[6]) else $error("rx2 not routed");
  int0_route_a: assert property ((ext_int_pin_on[0] && !sw_standby && $stable(port8_in[0])) [*5]
    |-> !port8_drive.oe[0] && ext_int_n[0] == port8_in[0]) else $error("int0 not routed");
  int1_idle_a: assert property (!ext_int_pin_on[1] [*4] |-> ext_int_n[1]) else $error("int1 active while off");
  clk2_out_a: assert property ((serial_unit_two.sync_mode && !serial_unit_two.serial_clock_src_hi && !sw_standby
    && $stable(serial2_clock_out)) [*5] |-> port8_drive.oe[3] && port8_drive.out[3] == serial2_clock_out)
    else $error("clock2 not driven");
endmodule : gpio_ports_sva
bind gpio_ports_six_seven_eight gpio_ports_sva gpio_ports_sva_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hreadyout, .hrdata, .hresp, .hw_standby, .sw_standby, .port8_in, .serial_unit_two, .serial2_tx_pin,
  .serial2_clock_out, .ext_int_pin_on, .port6_drive, .port8_drive, .serial2_rx_pin, .ext_int_n);

//--- sim/tb.sv
// self-checking testbench for the port 6/7/8 gpio block
`timescale 1ns/1ns
module tb;
  import gpio_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hw_standby, sw_standby, serial1_tx_pin, serial2_tx_pin;
  logic serial1_clock_out, serial2_clock_out, serial1_rx_pin, serial2_rx_pin, serial1_clock_pin, serial2_clock_pin;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, hresp;
  logic [3:0] port7_in, ext_int_pin_on, ext_int_n;
  logic [7:0] port6_in, port8_in, board6, board8;
  serial_ctrl_word_type serial_unit_one, serial_unit_two;
  pin_drive_type port6_drive, port8_drive;
  int n_mismatch, checked;
  localparam logic [31:0] A6D = 32'h0003FA24;
  localparam logic [31:0] A6 = 32'h0003FA2C;
  localparam logic [31:0] A8D = 32'h0003FA34;
  localparam logic [31:0] A7 = 32'h0003FA38;
  localparam logic [31:0] A8 = 32'h0003FA3C;
  gpio_ports_six_seven_eight gpio_ports_six_seven_eight_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .hw_standby, .sw_standby, .port6_in,
    .port7_in, .port8_in, .serial_unit_one, .serial_unit_two, .serial1_tx_pin, .serial2_tx_pin, .serial1_clock_out,
    .serial2_clock_out, .ext_int_pin_on, .port6_drive, .port8_drive, .serial1_rx_pin, .serial2_rx_pin,
    .serial1_clock_pin, .serial2_clock_pin, .ext_int_n);
  board_pins board_pins_i (.port6_drive, .port8_drive, .board6, .board8, .port6_in, .port8_in);
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task summarize;
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  task xfer(input logic [31:0] a, input logic wr, input logic [7:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= 32'(d);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer
  task wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask : wr
  task rd(input string nm, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(a, 1'b0, 8'h00, r);
    chk(nm, r, exp);
  endtask : rd
  initial begin
    cyc(20000);
    n_mismatch++;
    summarize();
  end
  initial begin
    logic o;
    n_mismatch = 0;
    checked = 0;
    {hresetn, hsel, hwrite, hw_standby, sw_standby, htrans, haddr, hwdata} = '0;
    {serial1_tx_pin, serial2_tx_pin, serial_unit_one, serial_unit_two, ext_int_pin_on} = '0;
    {serial1_clock_out, serial2_clock_out} = 2'b11;
    port7_in = 4'hA;
    board6 = 8'h3C;
    board8 = 8'h80;
    cyc(20);
    hresetn <= 1'b1;
    cyc(2);
    rd("p6 dir", A6D, 32'h000000FF);
    rd("p8 dir", A8D, 32'h000000FF);
    chk("p6 drive", port6_drive, 16'h0000);
    rd("p7", A7, 32'h0000000A);
    wr(A7, 8'h55);
    rd("p7 w", A7, 32'h0000000A);
    rd("unmapped", 32'h0003FA40, 32'h00000000);
    wr(A6D, 8'hF0);
    wr(A6, 8'h5A);
    wr(A8D, 8'h0F);
    wr(A8, 8'hA5);
    cyc(4);
    chk("p6 oe", port6_drive.oe, 8'hF0);
    chk("p6 out", port6_drive.out & 8'hF0, 8'h50);
    chk("p8 out", port8_drive.out & 8'h0F, 8'h05);
    rd("p6 data", A6, 32'h0000005C);
    rd("p8 data", A8, 32'h00000085);
    serial_unit_two <= 5'b00010;
    serial2_tx_pin <= 1'b1;
    cyc(6);
    chk("tx2 pin", {port8_drive.oe[7], port8_drive.out[7]}, 2'b11);
    sw_standby <= 1'b1;
    serial_unit_two <= 5'b00011;
    ext_int_pin_on <= 4'hF;
    cyc(6);
    chk("sw p6", port6_drive, 16'h5AF0);
    chk("sw p8 oe", port8_drive.oe, 8'h0F);
    chk("sw rx int", {serial2_rx_pin, ext_int_n}, 5'h1F);
    sw_standby <= 1'b0;
    ext_int_pin_on <= 4'h0;
    serial_unit_two <= 5'b00011;
    serial_unit_one <= 5'b00011;
    serial2_tx_pin <= 1'b0;
    serial1_tx_pin <= 1'b1;
    wr(A8D, 8'hFF);
    wr(A8, 8'h00);
    cyc(6);
    chk("p8 oe ser", port8_drive.oe, 8'hAF);
    chk("tx out", port8_drive.out & 8'hA0, 8'h20);
    chk("rx pins", {serial2_rx_pin, serial1_rx_pin}, 2'b00);
    ext_int_pin_on <= 4'hF;
    for (int i = 0; i < 8; i++) begin
      serial_unit_two <= {3'(i), 2'b00};
      serial_unit_one <= {3'(i), 2'b00};
      cyc(6);
      o = (i == 1) || (i == 4) || (i == 5);
      chk("ck oe", port8_drive.oe[3:2], {o, o});
      chk("ck out", port8_drive.out[3:2] & {o, o}, {o, o});
      chk("ck in", {serial2_clock_pin, serial1_clock_pin}, {!i[1], !i[1]});
      chk("int32", ext_int_n[3:2], {i != 0, i != 0});
    end
    chk("int10", {port8_drive.oe[1:0], ext_int_n[1:0]}, 4'h0);
    {serial_unit_one, serial_unit_two, ext_int_pin_on} <= '0;
    cyc(6);
    chk("gpio low", {port8_drive.oe[3:0], ext_int_n}, 8'hFF);
    hw_standby <= 1'b1;
    cyc(8);
    chk("hw p6", port6_drive, 16'h0000);
    chk("hw p8", port8_drive, 16'h0000);
    hw_standby <= 1'b0;
    cyc(4);
    rd("p8 after", A8, 32'h00000080);
    summarize();
  end
endmodule : tb
